// ===== hw/mag_switch_map.svh
`ifndef MAG_SWITCH_MAP_SVH
`define MAG_SWITCH_MAP_SVH
// Timing in its own units, with counts derived at the 50 MHz clock.
`define CLK_PERIOD_NS     20
`define AWAKE_TIME_NS     50000
`define PERIOD_TIME_NS    50000000
`define AWAKE_CYCLES      (`AWAKE_TIME_NS / `CLK_PERIOD_NS)
`define PERIOD_CYCLES     (`PERIOD_TIME_NS / `CLK_PERIOD_NS)
// Switch points in gauss, signed field with south at the marked face positive.
`define OPERATE_GAUSS     16'sh0021
`define RELEASE_GAUSS     16'sh0017
`define FIELD_W           16
`define VALID_PHASES      2'h2
`endif

// ===== hw/mag_switch_pkg.sv
`default_nettype none
package mag_switch_pkg;
  typedef enum logic [1:0] {
    SLEEP = 2'h0,
    AWAKE = 2'h1
  } phase_t;
  typedef struct packed {
    logic outLow;
    logic outValid;
  } sense_out_t;
endpackage
`default_nettype wire

// ===== hw/duty_cycled_magnetic_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "mag_switch_map.svh"
module duty_cycled_magnetic_switch
  import mag_switch_pkg::*;
#(
  parameter int AWAKE_CYCLES  = `AWAKE_CYCLES,
  parameter int PERIOD_CYCLES = `PERIOD_CYCLES
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clkEn,
  input  wire logic signed [`FIELD_W-1:0] field,
  input  wire logic                      selIn,
  output logic                           selPullupEn,
  output logic                           outPin,
  output logic                           outValid,
  output logic                           awake
);

  // ------------------------------------------------------------
  // Hibernating timer
  // ------------------------------------------------------------
  phase_t      phase;
  logic [31:0] tick;
  logic        awakeEnd;
  logic        detected;
  logic        lastSel;
  logic        selSeen;
  logic [1:0]  phasesDone;
  logic        singlePole;
  logic        selChange;
  logic        partial;

  function automatic logic abovePoint(input logic signed [`FIELD_W-1:0] b,
                                      input logic signed [`FIELD_W-1:0] lvl,
                                      input logic sp);
    logic signed [`FIELD_W-1:0] mag;
    mag = (b < 0) ? -b : b;
    abovePoint = sp ? (b > lvl) : (mag > lvl);
  endfunction

  assign awakeEnd = (phase == AWAKE) && (tick == 32'(AWAKE_CYCLES - 1));
  assign awake    = (phase == AWAKE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= AWAKE;
      tick  <= 32'h0;
    end else if (clkEn) begin
      if (tick == 32'(PERIOD_CYCLES - 1)) begin
        tick  <= 32'h0;
        phase <= AWAKE;
      end else begin
        tick <= tick + 32'h1;
        if (awakeEnd) begin
          phase <= SLEEP;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Select pin and mode
  // ------------------------------------------------------------
  assign selPullupEn = awake;
  // High or open selects single-pole; sampled only while the pull-up holds it.
  assign singlePole = lastSel;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastSel <= 1'b1;
      selSeen <= 1'b0;
    end else if (clkEn && awake) begin
      lastSel <= selIn;
      selSeen <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Comparator with hysteresis, updated at the end of awake
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detected <= 1'b0;
    end else if (clkEn && awakeEnd) begin
      if (abovePoint(field, `OPERATE_GAUSS, singlePole)) begin
        detected <= 1'b1;
      end else if (!abovePoint(field, `RELEASE_GAUSS, singlePole)) begin
        detected <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outPin <= 1'b1;
    end else if (clkEn) begin
      outPin <= !detected;
    end
  end

  // ------------------------------------------------------------
  // Validity: two completed awake phases after power-up or a change
  // ------------------------------------------------------------
  // A change is only visible while the pull-up holds the pin, so it is caught while awake.
  assign selChange = awake && selSeen && (selIn != lastSel);

  // A change seen after the first awake cycle leaves this window short, so its end does not count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      partial <= 1'b0;
    end else if (clkEn) begin
      if (selChange) begin
        partial <= (tick != 32'h0) && !awakeEnd;
      end else if (awakeEnd) begin
        partial <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phasesDone <= 2'h0;
    end else if (clkEn) begin
      if (selChange) begin
        phasesDone <= 2'h0;
      end else if (awakeEnd && !partial && phasesDone != `VALID_PHASES) begin
        phasesDone <= phasesDone + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outValid <= 1'b0;
    end else if (clkEn) begin
      outValid <= (phasesDone == `VALID_PHASES);
    end
  end

  // ------------------------------------------------------------
  // Timer and mode checks
  // ------------------------------------------------------------
  AST_PULLUP_ONLY_AWAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd) |=> !selPullupEn && !awake)
    else $error("pull-up still on after awake end");
  AST_WAKE_AT_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && tick == 32'(PERIOD_CYCLES - 1)) |=> selPullupEn && tick == 32'h0)
    else $error("timer did not wake at period end");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
    !clkEn |=> $stable(tick) && $stable(outPin) && $stable(outValid))
    else $error("state moved while clock enable was low");
  AST_OPEN_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awake && selIn) |=> singlePole)
    else $error("high select did not give single-pole mode");
  AST_LOW_EITHER: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awake && !selIn) |=> !singlePole)
    else $error("low select did not give either-pole mode");

  // ------------------------------------------------------------
  // Comparator checks
  // ------------------------------------------------------------
  AST_NO_NORTH_SINGLE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && singlePole && field < 0 && !detected) |=> !detected)
    else $error("north field asserted in single-pole mode");
  AST_SINGLE_NORTH_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && singlePole && field < 0) |=> !detected)
    else $error("front-to-rear flux kept detection in single-pole mode");
  AST_OPERATE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && field > `OPERATE_GAUSS) |=> detected ##1 (!$past(clkEn) || !outPin))
    else $error("operate level did not drive output low");
  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && field < `RELEASE_GAUSS && field > -`RELEASE_GAUSS) |=> !detected)
    else $error("release level did not clear detection");
  AST_HOLD_BETWEEN: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && singlePole && field > `RELEASE_GAUSS && field <= `OPERATE_GAUSS) |=> $stable(detected))
    else $error("detection changed inside the hysteresis band");
  AST_HOLD_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (!awakeEnd) |=> $stable(detected))
    else $error("detection changed outside awake end");
  AST_OMNI_NORTH: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && !singlePole && field < -`OPERATE_GAUSS) |=> detected)
    else $error("north field missed in either-pole mode");
  AST_OMNI_NORTH_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && !singlePole && field < 0 && field >= -`RELEASE_GAUSS) |=> !detected)
    else $error("weak north field kept detection in either-pole mode");
  AST_OUT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
    clkEn |=> outPin == !$past(detected))
    else $error("output does not follow detection");

  // ------------------------------------------------------------
  // Validity checks
  // ------------------------------------------------------------
  AST_CHANGE_INVALID: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && selChange) |=> ##1 (!$past(clkEn) || !outValid))
    else $error("output valid right after select change");
  AST_POWERUP_INVALID: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && phasesDone != `VALID_PHASES) |=> !outValid)
    else $error("valid before two phases");
  AST_PARTIAL_SKIPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && awakeEnd && partial && !selChange) |=> phasesDone == 2'h0)
    else $error("short awake window counted toward validity");
  AST_VALID_AFTER_TWO: assert property (@(posedge clk) disable iff (!rst_n)
    (clkEn && phasesDone == `VALID_PHASES) |=> outValid)
    else $error("output not valid after two phases");

  // ------------------------------------------------------------
  // Coverage
  // ------------------------------------------------------------
  COV_DETECT: cover property (@(posedge clk) disable iff (!rst_n) $fell(outPin));
  COV_RELEASE: cover property (@(posedge clk) disable iff (!rst_n) $rose(outPin));
  COV_MODE_CHANGE: cover property (@(posedge clk) disable iff (!rst_n) $fell(outValid));
  COV_SHORT_WINDOW: cover property (@(posedge clk) disable iff (!rst_n) clkEn && selChange && tick != 32'h0);
  COV_FREEZE_AWAKE: cover property (@(posedge clk) disable iff (!rst_n) !clkEn && awake);

endmodule
`default_nettype wire

// ===== tb/mag_host.sv
`timescale 1ns/1ps
`default_nettype none
module mag_host (
  input  wire logic clk,
  input  wire logic selPullupEn,
  input  wire logic selOe_n,
  input  wire logic selLevel,
  output logic      selIn
);
  logic last;
  always_ff @(posedge clk) begin
    last <= selIn;
  end
  // A released pin floats in sleep, so it shows a changing level instead of a held one.
  assign selIn = !selOe_n ? selLevel : (selPullupEn ? 1'b1 : ~last);
endmodule
`default_nettype wire

// ===== tb/duty_cycled_magnetic_switch_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mag_switch_map.svh"
module duty_cycled_magnetic_switch_bench;
  logic               clk = 0, rst_n = 0, selOe_n = 1, selLevel = 1, det = 0, mode = 1, clkEn = 1;
  logic               selIn, selPullupEn, outPin, outValid, awake;
  logic signed [15:0] field = 16'sh0000, mag;
  logic [3:0]         notes[$];
  logic [3:0]         exp, held;
  int                 n_errors = 0, compares = 0, seed = 32, phases = 0;
  initial forever #10 clk = ~clk;
  duty_cycled_magnetic_switch #(.AWAKE_CYCLES(4), .PERIOD_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n),
    .clkEn(clkEn), .field(field), .selIn(selIn), .selPullupEn(selPullupEn), .outPin(outPin),
    .outValid(outValid), .awake(awake));
  mag_host host (.clk(clk), .selPullupEn(selPullupEn), .selOe_n(selOe_n), .selLevel(selLevel), .selIn(selIn));
  task summarize;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------
  // One sampling period with its expected result.
  // ----------------------------------------
  task sample(input logic signed [15:0] f);
    field = f;
    mag = (mode || f >= 0) ? f : -f;
    if (mag > `OPERATE_GAUSS) det = 1'b1;
    else if (mag <= `RELEASE_GAUSS) det = 1'b0;
    phases++;
    notes.push_back({2'h0, phases >= 2, ~det});
    @(negedge awake);
    #1;
  endtask
  task setMode(input logic m);
    selOe_n = m;
    selLevel = m;
    mode = m;
    phases = 0;
  endtask
  // A change inside an awake window leaves that window short, so one more period is needed.
  task setModeAwake(input logic m);
    @(posedge awake);
    @(posedge clk);
    #1;
    setMode(m);
    phases = -1;
  endtask
  // Clock enable low inside an awake window must hold the timer and every output.
  task freezeAwake;
    @(posedge awake);
    #1 clkEn = 1'b0;
    held = {awake, selPullupEn, outValid, outPin};
    repeat (6) @(posedge clk);
    #1;
    compares++;
    if ({awake, selPullupEn, outValid, outPin} !== held) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, {awake, selPullupEn, outValid, outPin}, held);
    end
    clkEn = 1'b1;
  endtask
  initial begin
    forever begin
      @(negedge awake);
      @(posedge clk);
      #1;
      exp = (notes.size() != 0) ? notes.pop_front() : 4'hF;
      compares++;
      if ({awake, selPullupEn, outValid, outPin} !== exp) begin
        n_errors++;
        $display("mismatch at %0t: got %h expected %h", $time, {awake, selPullupEn, outValid, outPin}, exp);
      end
    end
  end
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    sample(16'sh0000);
    sample(16'sh0022);
    sample(16'sh0018);
    sample(16'sh0017);
    sample(-16'sh0064);
    setMode(1'b0);
    sample(-16'sh0064);
    sample(-16'sh0022);
    sample(-16'sh0018);
    sample(-16'sh0017);
    setMode(1'b1);
    sample(-16'sh0040);
    sample(-16'sh0040);
    setModeAwake(1'b0);
    sample(16'sh0030);
    sample(-16'sh0030);
    sample(-16'sh0030);
    $display("directed test done");
    repeat (30) begin
      if (($random(seed) & 3) == 0) setMode(~mode);
      if (($random(seed) & 7) == 1) freezeAwake();
      sample(16'($random(seed) % 60));
    end
    $display("random test done");
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
